// *** rtl/cps_pkg.sv ***
// Package: constants and carrier types for the card presence and select block
package cps_pkg;

   // ********************************************************************
   // Interface count and first interface index
   // ********************************************************************
   localparam int unsigned CPS_NUM_IF     = 2;        // Two card interfaces
   localparam int unsigned CPS_FIRST_IF   = 0;        // Index of the first interface

   // ********************************************************************
   // Reset values
   // ********************************************************************
   localparam logic CPS_EN_FIRST_RST      = 1'b1;     // First interface on after reset
   localparam logic CPS_EN_SECOND_RST     = 1'b0;     // Second interface off after reset
   localparam logic CPS_ROUTE_RST         = 1'b0;     // Route low selects first routed card
   localparam logic CPS_CLASS_RST         = 1'b0;     // 0 = 3 V class, 1 = 1.8 V class
   localparam logic CPS_ROUTE_FN_RST      = 1'b0;     // Routing function off until strapped

   // ********************************************************************
   // Timing: card clock divider
   // ********************************************************************
   localparam int unsigned CPS_SYS_HZ     = 50_000_000;   // System clock rate
   localparam int unsigned CPS_CARD_HZ    = 5_000_000;    // Card clock rate, upper bound
   // Half period of card clock in system cycles, rounded down (shortest time)
   localparam int unsigned CPS_HALF_CYC   = (CPS_SYS_HZ / CPS_CARD_HZ) / 2;
   localparam int unsigned CPS_DIV_W      = 4;            // Divider counter width

   // ********************************************************************
   // Per-interface carrier types
   // ********************************************************************
   typedef enum logic [1:0] {
      CPS_OFF,        // Interface powered down, outputs low, data line released
      CPS_ACTIVE,     // Supply on, clock running, lines follow the core
      CPS_REMOVED     // Card pulled while active: shut down, wait for restart
   } cps_state_t;

   // Core-side request for one interface
   typedef struct packed {
      logic reset_n_req;   // Card reset level wanted by the core
      logic io_out;        // Serial data to drive (open drain: 0 drives low)
      logic low_volt;      // 1 = 1.8 V class card, 0 = 3 V class card
   } cps_core_req_t;

   // Pin-side drive for one interface
   typedef struct packed {
      logic supply;        // Card supply enable
      logic low_volt;      // Level selection for the pad ring
      logic clock;         // Card clock
      logic reset;         // Card reset line
      logic io_oe;         // Data line drive enable (drives low)
   } cps_pin_drv_t;

endpackage

// *** rtl/cps_card_presence_select.sv ***
// Card presence watch, interface enable and card routing select logic
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Two independent card interfaces, five lines each
// - Each interface runs 3 V or 1.8 V cards
// - Tray detect is active low
// - Card removal shuts active interface down immediately
// - Only first interface enabled unless second_if_cfg is set
// - Route output low first card, high second
// - Routing function stored, applied from next restart
module cps_card_presence_select
   import cps_pkg::*;
#(
   parameter int unsigned NUM_IF = CPS_NUM_IF        // Number of card interfaces
)(
   input  wire logic                  clk,                 // 50 MHz system clock
   input  wire logic                  nrst,                // Async reset, active low
   input  wire logic [NUM_IF-1:0]     card_tray_detect_n,  // Tray present when low (pins)
   input  wire logic [NUM_IF-1:0]     card_serial_io_in,   // Data line level (pins)
   input  wire logic [NUM_IF-1:0]     if_enable_req,       // Core enable per interface
   input  wire logic                  second_if_cfg,       // Configuration: allow second
   input  wire cps_core_req_t [NUM_IF-1:0] core_req,       // Core reset, data, class
   input  wire logic                  route_fn_stored,     // Non-volatile route setting
   input  wire logic                  route_second,        // Core picks second routed card
   output logic [NUM_IF-1:0]          card_supply_out,     // Card supply enable
   output logic [NUM_IF-1:0]          card_low_volt_out,   // 1.8 V level select
   output logic [NUM_IF-1:0]          card_clock_out,      // Card clock
   output logic [NUM_IF-1:0]          card_reset_out,      // Card reset line
   output logic [NUM_IF-1:0]          card_serial_io_out,  // Data output level (always 0)
   output logic [NUM_IF-1:0]          card_serial_io_oe,   // Data drive enable
   output logic [NUM_IF-1:0]          card_serial_io_rx,   // Synchronised data to core
   output logic [NUM_IF-1:0]          card_removed,        // Interface shut by removal
   output logic                       shared_route_pin_out,// Route select level
   output logic                       shared_route_pin_oe  // Route pin drive enable
);

   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   logic [NUM_IF-1:0] det_meta_reg;    // First stage, read only by second
   logic [NUM_IF-1:0] det_sync_reg;    // Detect, safe to use
   logic [NUM_IF-1:0] io_meta_reg;     // First stage of data line
   logic [NUM_IF-1:0] io_sync_reg;     // Data line, safe to use

   // Two flops each; both lines arrive from the card holder
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         det_meta_reg <= '1;            // Absent until seen
         det_sync_reg <= '1;
         io_meta_reg  <= '1;
         io_sync_reg  <= '1;
      end else begin
         det_meta_reg <= card_tray_detect_n;
         det_sync_reg <= det_meta_reg;
         io_meta_reg  <= card_serial_io_in;
         io_sync_reg  <= io_meta_reg;
      end
   end

   // ********************************************************************
   // Card clock divider, shared by both interfaces
   // ********************************************************************
   localparam logic [CPS_DIV_W-1:0] HALF_LAST = CPS_DIV_W'(CPS_HALF_CYC - 1);
   logic [CPS_DIV_W-1:0] div_reg, div_next;   // Half-period counter
   logic                 tick_reg, tick_next; // Free-running divided clock

   always_comb begin
      div_next  = div_reg + 1'b1;
      tick_next = tick_reg;
      if (div_reg == HALF_LAST) begin
         div_next  = '0;
         tick_next = ~tick_reg;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   // ********************************************************************
   // Route function strap, caught once after reset release
   // ********************************************************************
   // A setting changed at run time only counts after the next restart,
   // so the stored value is sampled once and then frozen.
   logic caught_reg, caught_next;     // Strap already sampled
   logic route_fn_reg, route_fn_next; // Route function active this run
   logic route_reg, route_next;       // Route level
   logic route_oe_reg, route_oe_next; // Route drive enable

   always_comb begin
      caught_next   = 1'b1;
      route_fn_next = caught_reg ? route_fn_reg : route_fn_stored;
      // Low unless function active and second card chosen
      route_next    = route_fn_reg & route_second;
      route_oe_next = route_fn_reg;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         caught_reg   <= 1'b0;
         route_fn_reg <= CPS_ROUTE_FN_RST;
         route_reg    <= CPS_ROUTE_RST;
         route_oe_reg <= 1'b0;
      end else begin
         caught_reg   <= caught_next;
         route_fn_reg <= route_fn_next;
         route_reg    <= route_next;
         route_oe_reg <= route_oe_next;
      end
   end

   assign shared_route_pin_out = route_reg;
   assign shared_route_pin_oe  = route_oe_reg;

   // ********************************************************************
   // Per-interface state machines and pin drive
   // ********************************************************************
   cps_state_t   st_reg   [NUM_IF];   // Interface states
   cps_state_t   st_next  [NUM_IF];
   cps_pin_drv_t drv_reg  [NUM_IF];   // Registered pin drive
   cps_pin_drv_t drv_next [NUM_IF];
   logic [NUM_IF-1:0] allowed;        // Enable gate per interface
   logic [NUM_IF-1:0] removed_reg;    // Removal flag, registered for the pin
   logic [NUM_IF-1:0] removed_next;   // Next removal flag

   // Only the first interface may run unless configured
   always_comb begin
      for (int i = 0; i < NUM_IF; i++) begin
         allowed[i] = (i == CPS_FIRST_IF) ? CPS_EN_FIRST_RST : second_if_cfg;
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_IF; i++) begin
         st_next[i] = st_reg[i];
         case (st_reg[i])
            CPS_OFF: begin
               // Start only with tray present (low)
               if (if_enable_req[i] && allowed[i] && !det_sync_reg[i]) begin
                  st_next[i] = CPS_ACTIVE;
               end
            end
            CPS_ACTIVE: begin
               if (det_sync_reg[i]) begin
                  st_next[i] = CPS_REMOVED;
               end else if (!if_enable_req[i] || !allowed[i]) begin
                  st_next[i] = CPS_OFF;
               end
            end
            CPS_REMOVED: begin
               // Stays shut; recovery needs a module restart
               st_next[i] = CPS_REMOVED;
            end
            default: begin
               st_next[i] = CPS_OFF;
            end
         endcase
         // Flag rises on the same edge as the shutdown
         removed_next[i] = (st_next[i] == CPS_REMOVED);
         // Drive follows next state so a removal drops lines on the same edge
         drv_next[i] = '0;
         if (st_next[i] == CPS_ACTIVE) begin
            drv_next[i].supply   = 1'b1;
            drv_next[i].low_volt = core_req[i].low_volt;
            drv_next[i].clock    = tick_next;
            drv_next[i].reset    = core_req[i].reset_n_req;
            drv_next[i].io_oe    = ~core_req[i].io_out;       // Open drain
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_IF; i++) begin
            st_reg[i]  <= CPS_OFF;
            drv_reg[i] <= '0;
         end
         removed_reg <= '0;
      end else begin
         for (int i = 0; i < NUM_IF; i++) begin
            st_reg[i]  <= st_next[i];
            drv_reg[i] <= drv_next[i];
         end
         removed_reg <= removed_next;
      end
   end

   // Pins straight from flops
   always_comb begin
      for (int i = 0; i < NUM_IF; i++) begin
         card_supply_out[i]    = drv_reg[i].supply;
         card_low_volt_out[i]  = drv_reg[i].low_volt;
         card_clock_out[i]     = drv_reg[i].clock;
         card_reset_out[i]     = drv_reg[i].reset;
         card_serial_io_oe[i]  = drv_reg[i].io_oe;
         card_serial_io_out[i] = 1'b0;
         card_removed[i]       = removed_reg[i];
      end
   end

   assign card_serial_io_rx = io_sync_reg;

   // ********************************************************************
   // Checks
   // ********************************************************************
   for (genvar g = 0; g < NUM_IF; g++) begin : g_chk
      a_removal_shuts_down: assert property (
         @(posedge clk) disable iff (!nrst)
         (st_reg[g] == CPS_ACTIVE && det_sync_reg[g]) |=> !card_supply_out[g] && card_removed[g])
         else $error("interface not shut down after removal");
      a_removed_stays_off: assert property (
         @(posedge clk) disable iff (!nrst)
         card_removed[g] |=> card_removed[g] && !card_supply_out[g] && !card_clock_out[g])
         else $error("removed interface came back");
      a_absent_no_start: assert property (
         @(posedge clk) disable iff (!nrst)
         (st_reg[g] == CPS_OFF && det_sync_reg[g]) |=> !card_supply_out[g])
         else $error("interface started with tray absent");
      a_level_follows: assert property (
         @(posedge clk) disable iff (!nrst)
         card_supply_out[g] |-> card_low_volt_out[g] == $past(core_req[g].low_volt))
         else $error("card class level wrong");
   end

   a_second_gated: assert property (
      @(posedge clk) disable iff (!nrst)
      (!$past(second_if_cfg) && NUM_IF > 1) |-> !card_supply_out[NUM_IF-1])
      else $error("second interface ran without configuration");
   a_route_level: assert property (
      @(posedge clk) disable iff (!nrst)
      route_fn_reg |=> shared_route_pin_out == $past(route_second) && shared_route_pin_oe)
      else $error("route level does not follow selection");
   a_route_default: assert property (
      @(posedge clk) disable iff (!nrst)
      !route_fn_reg |=> !shared_route_pin_out)
      else $error("route not low when function off");
   a_route_frozen: assert property (
      @(posedge clk) disable iff (!nrst)
      caught_reg |=> $stable(route_fn_reg))
      else $error("route function changed before restart");

endmodule

`default_nettype wire

// *** bench/cps_card_model.sv ***
// Card holder model: tray switch and open-drain data line of one card
`timescale 1ns/10ps
`default_nettype none
module cps_card_model (
   input  wire logic supply,     // Card supply from the block
   input  wire logic host_pull,  // Block pulls data low
   input  wire logic present,    // Bench: tray seated
   input  wire logic card_pull,  // Bench: card sends a low bit
   output logic      tray_n,     // Detect switch, low when seated
   output logic      io_level    // Resolved data level
);
   // Switch to ground when seated, wired to nothing else
   assign tray_n = ~present;
   // Pull-up wins unless someone pulls; unpowered card cannot pull
   assign io_level = ~(host_pull | (card_pull & supply & present));
endmodule
`default_nettype wire

// *** bench/cps_card_presence_select_tb.sv ***
// Self-checking bench for the card presence and select block
`timescale 1ns/10ps
`default_nettype none
module cps_card_presence_select_tb;
   import cps_pkg::*;
   // ****************************************************
   // Signals
   // ****************************************************
   logic                clk, nrst, second_if_cfg, strap, route_second;
   logic [1:0]          en, present, card_pull, tray_n, io_lvl;
   cps_core_req_t [1:0] core_req;         // Core side requests
   logic [1:0]          supply, lv, cclk, crst, io_o, io_oe, io_rx, removed;
   logic                route_out, route_oe;
   int                  n_errors, checks_done;
   cps_card_presence_select dut (.clk(clk), .nrst(nrst), .card_tray_detect_n(tray_n),
      .card_serial_io_in(io_lvl), .if_enable_req(en), .second_if_cfg(second_if_cfg),
      .core_req(core_req), .route_fn_stored(strap), .route_second(route_second),
      .card_supply_out(supply), .card_low_volt_out(lv), .card_clock_out(cclk),
      .card_reset_out(crst), .card_serial_io_out(io_o), .card_serial_io_oe(io_oe),
      .card_serial_io_rx(io_rx), .card_removed(removed),
      .shared_route_pin_out(route_out), .shared_route_pin_oe(route_oe));
   // One card holder per interface
   for (genvar i = 0; i < 2; i++) begin : g_card
      cps_card_model card (.supply(supply[i]), .host_pull(io_oe[i]), .present(present[i]),
         .card_pull(card_pull[i]), .tray_n(tray_n[i]), .io_level(io_lvl[i]));
   end
   // ****************************************************
   // Helpers
   // ****************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Inputs move 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Host restart, strap held across release
   task automatic do_reset(input logic s);
      nrst = 1'b0;
      strap = s;
      tick(6);
      nrst = 1'b1;
      tick(3);
   endtask
   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_run(input logic cls);
      int tr;
      logic prev;
      core_req[0] = '{reset_n_req: 1'b1, io_out: 1'b1, low_volt: cls};
      en[0] = 1'b1;
      present[0] = 1'b1;
      tick(3);
      chk({supply[0], lv[0], crst[0]}, {1'b1, cls, 1'b1}, "start");
      core_req[0].io_out = 1'b0;
      tick(3);
      chk({io_oe[0], io_o[0], io_rx[0]}, 8'h04, "host drive");
      core_req[0].io_out = 1'b1;
      card_pull[0] = 1'b1;
      // Four edges: a released line would show through the synchroniser by now
      tick(4);
      chk({io_oe[0], io_rx[0]}, 8'h00, "card drive");
      card_pull[0] = 1'b0;
      tr = 0;
      prev = cclk[0];
      for (int k = 0; k < 40; k++) begin
         tick(1);
         if (cclk[0] !== prev) tr++;
         prev = cclk[0];
      end
      chk(8'(tr), 8'h08, "card clock");
      chk(io_rx[0], 1'b1, "line released");
      en[0] = 1'b0;
      tick(3);
      chk({supply[0], removed[0]}, 8'h00, "disable");
      $display("test run class %0d done", cls);
   endtask
   task automatic t_second();
      en = 2'b11;
      tick(3);
      chk(supply, 8'h01, "second off");
      second_if_cfg = 1'b1;
      tick(3);
      chk(supply, 8'h01, "second tray absent");
      present[1] = 1'b1;
      tick(3);
      chk(supply, 8'h03, "second on");
      // Configuration withdrawn while running stops the second interface
      second_if_cfg = 1'b0;
      tick(2);
      chk(supply, 8'h01, "second gated again");
      second_if_cfg = 1'b1;
      tick(2);
      chk(supply, 8'h03, "second back on");
      $display("test second interface done");
   endtask
   task automatic t_removal();
      core_req[0].io_out = 1'b0;
      tick(2);
      present[0] = 1'b0;
      tick(3);
      chk({supply[0], crst[0], io_oe[0], cclk[0], removed[0]}, 8'h01, "shutdown");
      chk(supply[1], 1'b1, "other untouched");
      present[0] = 1'b1;
      tick(6);
      chk({supply[0], removed[0]}, 8'h01, "reinsert held");
      do_reset(1'b0);
      chk({supply[0], removed[0]}, 8'h02, "after restart");
      $display("test removal done");
   endtask
   task automatic t_route();
      route_second = 1'b1;
      tick(2);
      chk({route_oe, route_out}, 8'h00, "route off");
      strap = 1'b1;
      tick(3);
      chk({route_oe, route_out}, 8'h00, "strap not live");
      do_reset(1'b1);
      strap = 1'b0;
      for (int v = 0; v < 2; v++) begin
         route_second = v[0];
         tick(2);
         chk({route_oe, route_out}, {7'h01, v[0]}, "route level");
      end
      $display("test route done");
   endtask
   // ****************************************************
   // Verdict and sequence
   // ****************************************************
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      n_errors = 0;
      checks_done = 0;
      {en, present, card_pull, second_if_cfg, route_second} = '0;
      core_req = '0;
      do_reset(1'b0);
      chk({supply, removed, io_rx, route_oe}, 8'h06, "reset values");
      t_run(1'b0);
      t_run(1'b1);
      t_second();
      t_removal();
      t_route();
      conclude();
   end
   // Whole run is well under 1000 cycles
   initial begin
      #(20 * 3000);
      n_errors++;
      conclude();
   end
endmodule
`default_nettype wire
